// >>> common/lars_consts.vh
// Constants for the line autoreclose sequencer.
// Assumes a 100 MHz scheme clock and a 60 Hz power system.
`ifndef LARS_CONSTS_VH
`define LARS_CONSTS_VH

// Clock and time base
`define LARS_CLK_HZ 100000000
`define LARS_TICK_S_DIV 100
`define LARS_TICK_CYC (`LARS_CLK_HZ / `LARS_TICK_S_DIV)
`define LARS_TICK_W 20
`define LARS_LINE_HZ 60
`define LARS_FORCE_CYC_X100 125
`define LARS_FORCE_CYC (`LARS_CLK_HZ / `LARS_LINE_HZ * `LARS_FORCE_CYC_X100 / 100)
`define LARS_FORCE_W 22

// Settings widths
`define LARS_TIME_W 16
`define LARS_SHOT_W 3

// Reclose programs
`define LARS_MODE_1AND3 2'h0
`define LARS_MODE_1POLE 2'h1
`define LARS_MODE_3A 2'h2
`define LARS_MODE_3B 2'h3

// Breaker order
`define LARS_SEQ_B1 2'h0
`define LARS_SEQ_B2 2'h1
`define LARS_SEQ_12 2'h2
`define LARS_SEQ_21 2'h3

// Dead timer selection
`define LARS_DT_SP 3'h0
`define LARS_DT_3P1 3'h1
`define LARS_DT_3P2 3'h2
`define LARS_DT_3P3 3'h3
`define LARS_DT_3P4 3'h4

`endif

// >>> rtl/lars_timer.v
// Settable down-counting timer in 0.01 s ticks.
// Assumes a one-cycle tick enable from the parent.
`timescale 1ns/100ps
module lars_timer
#(
	parameter W = 16
)
(
	// Clock and reset
	input wire mclk_i,
	input wire resetn_i,
	// Control
	input wire start_i,
	input wire stop_i,
	input wire hold_i,
	input wire tick_i,
	input wire [W-1:0] load_i,
	// Status
	output reg run_o,
	output reg done_o
);
	reg [W-1:0] count;

	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			count <= {W{1'b0}};
			run_o <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			if (stop_i)
				run_o <= 1'b0;
			else if (start_i)
			begin
				count <= load_i;
				run_o <= 1'b1;
			end
			else if (run_o && !hold_i)
			begin
				// Zero setting expires at once
				if (count == {W{1'b0}})
				begin
					run_o <= 1'b0;
					done_o <= 1'b1;
				end
				else if (tick_i)
					count <= count - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> rtl/lars_sequencer.v
// Autoreclose sequencer for one or two breakers.
// Assumes initiate and status inputs come from pins; settings are static.
`timescale 1ns/100ps
`include "lars_consts.vh"
module lars_sequencer
#(
	parameter TW = `LARS_TIME_W,
	parameter SW = `LARS_SHOT_W,
	parameter TICK_CYC = `LARS_TICK_CYC,
	parameter FORCE_CYC = `LARS_FORCE_CYC
)
(
	// Clock and reset
	input wire mclk_i,
	input wire resetn_i,
	input wire sync_reset_i,
	// Initiates and fault type
	input wire sp_initiate_i,
	input wire tp_initiate_i,
	input wire delayed_three_pole_initiate_i,
	input wire multi_phase_fault_i,
	input wire cycle_pause_input_i,
	input wire lockout_release_i,
	input wire manual_close_i,
	// Breaker status
	input wire bkr1_closed_i,
	input wire bkr2_closed_i,
	input wire bkr1_three_pole_open_i,
	input wire bkr1_oos_i,
	input wire bkr2_oos_i,
	// Settings
	input wire [1:0] reclose_program_select_i,
	input wire [1:0] breaker_order_select_i,
	input wire [SW-1:0] max_shot_limit_i,
	input wire close_failure_policy_i,
	input wire [TW-1:0] sp_dead_time_i,
	input wire [TW-1:0] tp_dead_time1_i,
	input wire [TW-1:0] tp_dead_time2_i,
	input wire [TW-1:0] tp_dead_time3_i,
	input wire [TW-1:0] tp_dead_time4_i,
	input wire [TW-1:0] reset_time_i,
	input wire [TW-1:0] incomplete_time_i,
	input wire [TW-1:0] transfer_time_i,
	input wire [TW-1:0] close_fail_time_i,
	// Outputs
	output reg reclose_in_progress_flag_o,
	output reg close_cmd_breaker_one_o,
	output reg close_cmd_breaker_two_o,
	output wire force_three_pole_trip_o,
	output reg [SW-1:0] shot_counter_o,
	output reg lockout_o,
	output reg reset_state_o
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam NI = 12;
	wire [NI-1:0] raw = {sp_initiate_i, tp_initiate_i, delayed_three_pole_initiate_i,
		multi_phase_fault_i, cycle_pause_input_i, lockout_release_i, manual_close_i,
		bkr1_closed_i, bkr2_closed_i, bkr1_three_pole_open_i, bkr1_oos_i, bkr2_oos_i};
	reg [NI-1:0] s1;
	reg [NI-1:0] s2;
	reg [NI-1:0] s3;
	reg [NI-1:0] in_q;
	genvar g;
	generate
		for (g = 0; g < NI; g = g + 1)
		begin : g_sync
			always @(posedge mclk_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					s1[g] <= 1'b0;
					s2[g] <= 1'b0;
					s3[g] <= 1'b0;
					in_q[g] <= 1'b0;
				end
				else
				begin
					s1[g] <= raw[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					// Change counts once stages two and three agree
					if (s2[g] == s3[g])
						in_q[g] <= s3[g];
				end
			end
		end
	endgenerate
	wire sp_i = in_q[11];
	wire tp_i = in_q[10];
	wire td_i = in_q[9];
	wire multi = in_q[8];
	wire pause = in_q[7];
	wire release_lo = in_q[6];
	wire man_close = in_q[5];
	wire b1_closed = in_q[4];
	wire b2_closed = in_q[3];
	wire b1_3p_open = in_q[2];
	wire b1_oos = in_q[1];
	wire b2_oos = in_q[0];

	// ----------------------------------------
	// Tick divider and state
	// ----------------------------------------
	localparam ST_RESET = 4'b0001;
	localparam ST_RIP = 4'b0010;
	localparam ST_CLOSE = 4'b0100;
	localparam ST_LOCK = 4'b1000;

	reg [`LARS_TICK_W-1:0] tick_cnt;
	reg tick;
	reg [3:0] state;
	reg [3:0] next_state;
	reg tp_latch;
	reg td_latch;
	reg paused_seen;
	reg sp_run;
	reg [`LARS_FORCE_W-1:0] force_cnt;
	reg force_sp;
	reg [2:0] dt_sel;
	reg second_pending;

	wire any_init = sp_i | tp_i | td_i;
	wire init_rise;
	reg init_d;
	assign init_rise = any_init & ~init_d;
	wire two_bkr = breaker_order_select_i[1];
	wire seq_21 = (breaker_order_select_i == `LARS_SEQ_21);
	wire first_is_two = (breaker_order_select_i == `LARS_SEQ_B2) | seq_21;

	// Dead time for a given selector code
	function [TW-1:0] dead_time;
		input [2:0] sel;
		begin
			case (sel)
				`LARS_DT_SP: dead_time = sp_dead_time_i;
				`LARS_DT_3P1: dead_time = tp_dead_time1_i;
				`LARS_DT_3P2: dead_time = tp_dead_time2_i;
				`LARS_DT_3P3: dead_time = tp_dead_time3_i;
				default: dead_time = tp_dead_time4_i;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Dead timer selection
	// ----------------------------------------
	// Latched initiates keep the choice after a short trip pulse
	wire tp_now = tp_i | tp_latch;
	wire td_now = td_i | td_latch;
	reg [2:0] pick;
	reg pick_lock;
	always @*
	begin
		pick = `LARS_DT_3P1;
		pick_lock = 1'b0;
		if (shot_counter_o != {SW{1'b0}})
			pick = shot_counter_o + 3'h1;
		else
		begin
			case (reclose_program_select_i)
				`LARS_MODE_1AND3:
				begin
					if (td_now)
						pick = `LARS_DT_3P2;
					else if (tp_now)
						pick = `LARS_DT_3P1;
					else
						pick = `LARS_DT_SP;
				end
				`LARS_MODE_1POLE:
				begin
					pick = `LARS_DT_SP;
					pick_lock = tp_now | td_now | multi;
				end
				`LARS_MODE_3A:
				begin
					pick = `LARS_DT_3P1;
					pick_lock = multi | tp_now;
				end
				default:
					pick = td_now ? `LARS_DT_3P2 : `LARS_DT_3P1;
			endcase
		end
	end

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	wire dead_done;
	wire dead_run;
	wire rst_done;
	wire inc_done;
	wire xfer_done;
	wire fail_done;
	// Any accepted initiate edge starts timing, the one entering the cycle too
	wire dead_start = (state != ST_LOCK) & init_rise & ~pick_lock
		& (shot_counter_o != max_shot_limit_i);
	wire resume = paused_seen & ~pause & (state == ST_RIP);
	wire close_now = (state == ST_RIP) & dead_done;
	wire lock_now = (next_state == ST_LOCK) & (state != ST_LOCK);
	wire go_reset = (next_state == ST_RESET) & (state != ST_RESET);

	// Pause holds the dead timer; resume restarts with timer two.
	lars_timer #(.W(TW)) u_dead (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.start_i(dead_start | resume),
		.stop_i(sync_reset_i | lock_now),
		.hold_i(pause), .tick_i(tick),
		.load_i(resume ? tp_dead_time2_i : dead_time(pick)),
		.run_o(dead_run), .done_o(dead_done));
	lars_timer #(.W(TW)) u_reset (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.start_i(close_now),
		.stop_i(sync_reset_i | any_init | lock_now | man_close | release_lo),
		.hold_i(1'b0), .tick_i(tick), .load_i(reset_time_i),
		.run_o(), .done_o(rst_done));
	lars_timer #(.W(TW)) u_inc (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.start_i((state != ST_RIP) & (next_state == ST_RIP)),
		.stop_i(sync_reset_i | close_now | lock_now),
		.hold_i(pause), .tick_i(tick), .load_i(incomplete_time_i),
		.run_o(), .done_o(inc_done));
	lars_timer #(.W(TW)) u_xfer (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.start_i(close_now & two_bkr),
		.stop_i(sync_reset_i | any_init | lock_now),
		.hold_i(1'b0), .tick_i(tick), .load_i(transfer_time_i),
		.run_o(), .done_o(xfer_done));
	wire cmd_open_fail = (close_cmd_breaker_one_o & ~b1_closed)
		| (close_cmd_breaker_two_o & ~b2_closed);
	lars_timer #(.W(TW)) u_fail (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.start_i(close_now | xfer_done),
		// Commands rise one edge after the start, so spare that edge
		.stop_i(sync_reset_i | lock_now | (~cmd_open_fail & ~close_now & ~xfer_done)),
		.hold_i(1'b0), .tick_i(tick), .load_i(close_fail_time_i),
		.run_o(), .done_o(fail_done));

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	wire [1:0] in_service_open = {~b1_oos & ~b1_closed, ~b2_oos & ~b2_closed};
	wire bkrs_ok = two_bkr ? ((in_service_open == 2'h0) & (b1_closed | b2_closed))
		: (first_is_two ? b2_closed : b1_closed);
	always @*
	begin
		next_state = state;
		case (state)
			ST_RESET, ST_CLOSE:
			begin
				if (init_rise && shot_counter_o == max_shot_limit_i)
					next_state = ST_LOCK;
				else if (init_rise && pick_lock)
					next_state = ST_LOCK;
				else if (any_init)
					next_state = ST_RIP;
				else if (rst_done)
					next_state = bkrs_ok ? ST_RESET : ST_LOCK;
				else if (fail_done && two_bkr && !close_failure_policy_i)
					next_state = ST_LOCK;
			end
			ST_RIP:
			begin
				if (pick_lock && init_rise)
					next_state = ST_LOCK;
				else if (sp_run && b1_3p_open
					&& reclose_program_select_i == `LARS_MODE_1POLE)
					next_state = ST_LOCK;
				else if (shot_counter_o == max_shot_limit_i && init_rise)
					next_state = ST_LOCK;
				else if (inc_done)
					next_state = ST_LOCK;
				else if (dead_done)
					next_state = ST_CLOSE;
			end
			ST_LOCK:
				if (release_lo || man_close)
					next_state = ST_RESET;
			default:
				next_state = ST_RESET;
		endcase
	end

	// ----------------------------------------
	// Sequential state
	// ----------------------------------------
	always @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tick_cnt <= {`LARS_TICK_W{1'b0}};
			tick <= 1'b0;
			state <= ST_RESET;
			init_d <= 1'b0;
			tp_latch <= 1'b0;
			td_latch <= 1'b0;
			paused_seen <= 1'b0;
			sp_run <= 1'b0;
			force_cnt <= {`LARS_FORCE_W{1'b0}};
			force_sp <= 1'b0;
			dt_sel <= `LARS_DT_SP;
			second_pending <= 1'b0;
			shot_counter_o <= {SW{1'b0}};
			close_cmd_breaker_one_o <= 1'b0;
			close_cmd_breaker_two_o <= 1'b0;
			reclose_in_progress_flag_o <= 1'b0;
			lockout_o <= 1'b0;
			reset_state_o <= 1'b1;
		end
		else if (sync_reset_i)
		begin
			// Synchronous scheme reset
			tick_cnt <= {`LARS_TICK_W{1'b0}};
			tick <= 1'b0;
			state <= ST_RESET;
			init_d <= 1'b0;
			tp_latch <= 1'b0;
			td_latch <= 1'b0;
			paused_seen <= 1'b0;
			sp_run <= 1'b0;
			force_cnt <= {`LARS_FORCE_W{1'b0}};
			force_sp <= 1'b0;
			second_pending <= 1'b0;
			shot_counter_o <= {SW{1'b0}};
			close_cmd_breaker_one_o <= 1'b0;
			close_cmd_breaker_two_o <= 1'b0;
			reclose_in_progress_flag_o <= 1'b0;
			lockout_o <= 1'b0;
			reset_state_o <= 1'b1;
		end
		else
		begin
			tick <= (tick_cnt == TICK_CYC - 1);
			tick_cnt <= (tick_cnt == TICK_CYC - 1) ? {`LARS_TICK_W{1'b0}}
				: tick_cnt + {{(`LARS_TICK_W-1){1'b0}}, 1'b1};
			state <= next_state;
			init_d <= any_init;
			reclose_in_progress_flag_o <= (next_state == ST_RIP);
			lockout_o <= (next_state == ST_LOCK);
			reset_state_o <= (next_state == ST_RESET);
			if (dead_start)
				dt_sel <= pick;

			// Initiate latches
			if (close_now || lock_now || go_reset)
			begin
				tp_latch <= 1'b0;
				td_latch <= 1'b0;
			end
			else
			begin
				tp_latch <= tp_latch | tp_i;
				td_latch <= td_latch | td_i;
			end

			if (pause && state == ST_RIP)
				paused_seen <= 1'b1;
			else if (!pause)
				paused_seen <= 1'b0;

			// Evolving fault timing
			sp_run <= dead_run & (dt_sel == `LARS_DT_SP);
			if (lock_now || go_reset)
			begin
				force_cnt <= {`LARS_FORCE_W{1'b0}};
				force_sp <= 1'b0;
			end
			else if (sp_run && !force_sp)
			begin
				if (force_cnt == FORCE_CYC - 1)
					force_sp <= 1'b1;
				force_cnt <= force_cnt + {{(`LARS_FORCE_W-1){1'b0}}, 1'b1};
			end

			// Close commands and shot count
			if (lock_now || go_reset)
			begin
				close_cmd_breaker_one_o <= 1'b0;
				close_cmd_breaker_two_o <= 1'b0;
				second_pending <= 1'b0;
				if (go_reset)
					shot_counter_o <= {SW{1'b0}};
			end
			else if (close_now)
			begin
				shot_counter_o <= shot_counter_o + 3'h1;
				if (breaker_order_select_i == `LARS_SEQ_B1 || !first_is_two)
					close_cmd_breaker_one_o <= 1'b1;
				else
					close_cmd_breaker_two_o <= 1'b1;
				second_pending <= two_bkr;
			end
			else
			begin
				if (xfer_done && second_pending)
				begin
					second_pending <= 1'b0;
					if (seq_21)
						close_cmd_breaker_one_o <= 1'b1;
					else
						close_cmd_breaker_two_o <= 1'b1;
				end
				else if (fail_done && two_bkr && close_failure_policy_i)
				begin
					// Continue on the other breaker
					close_cmd_breaker_one_o <= close_cmd_breaker_two_o;
					close_cmd_breaker_two_o <= close_cmd_breaker_one_o;
					second_pending <= 1'b0;
					if (shot_counter_o != {SW{1'b0}})
						shot_counter_o <= shot_counter_o - 3'h1;
				end
				else
				begin
					if (b1_closed)
						close_cmd_breaker_one_o <= 1'b0;
					if (b2_closed)
						close_cmd_breaker_two_o <= 1'b0;
				end
			end
		end
	end

	// Pause in ST_RIP and nonzero count both demand three-pole tripping
	assign force_three_pole_trip_o = force_sp | lockout_o
		| (shot_counter_o != {SW{1'b0}})
		| (pause & (state == ST_RIP))
		| reclose_program_select_i[1];
endmodule

// >>> test/lars_breaker_model.sv
// Behavioural circuit breaker at the far side of the sequencer.
// Assumes close, trip and stuck are levels on the scheme clock.
`timescale 1ns/100ps
module lars_breaker_model
#(
	parameter DELAY = 3
)
(
	// Commands
	input wire mclk_i,
	input wire close_i,
	input wire trip_i,
	input wire stuck_i,
	// Status
	output reg closed_o,
	output wire open_o
);
	integer cnt;
	assign open_o = !closed_o;
	initial
	begin
		closed_o = 1'b1;
		cnt = 0;
	end
	// Stuck mechanism ignores close, so a failed reclose can be staged
	always @(posedge mclk_i)
	begin
		if (trip_i)
		begin
			closed_o <= 1'b0;
			cnt <= 0;
		end
		else if (close_i && !stuck_i)
		begin
			cnt <= cnt + 1;
			if (cnt >= DELAY)
				closed_o <= 1'b1;
		end
		else
			cnt <= 0;
	end
endmodule

// >>> test/lars_sequencer_sva.sv
// Port checker for the autoreclose sequencer.
// Assumes settings stay static while a sequence runs.
`timescale 1ns/100ps
module lars_sequencer_sva
#(
	parameter SW = 3
)
(
	// Clock, reset and inputs
	input wire mclk_i,
	input wire resetn_i,
	input wire sync_reset_i,
	input wire cycle_pause_input_i,
	input wire [1:0] breaker_order_select_i,
	input wire [SW-1:0] max_shot_limit_i,
	// Outputs watched
	input wire reclose_in_progress_flag_o,
	input wire close_cmd_breaker_one_o,
	input wire close_cmd_breaker_two_o,
	input wire force_three_pole_trip_o,
	input wire [SW-1:0] shot_counter_o,
	input wire lockout_o,
	input wire reset_state_o
);
	wire rip = reclose_in_progress_flag_o;
	wire c1 = close_cmd_breaker_one_o;
	wire c2 = close_cmd_breaker_two_o;
	wire [SW-1:0] shot = shot_counter_o;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	chk_rip_release:
	assert property ($fell(rip) |-> c1 || c2 || $past(c1 || c2) || lockout_o || reset_state_o)
		else $error("In-progress flag dropped without close or lockout");
	chk_order_one:
	assert property (c1 |-> breaker_order_select_i != 2'h1)
		else $error("Breaker one closed outside its order");
	chk_order_two:
	assert property (c2 |-> breaker_order_select_i != 2'h0)
		else $error("Breaker two closed outside its order");
	chk_lock_close:
	assert property ($rose(lockout_o) |-> ##[0:1] !(c1 || c2))
		else $error("Close command kept in lockout");
	chk_pause_force:
	assert property ($rose(cycle_pause_input_i) && rip |-> ##[1:8] force_three_pole_trip_o)
		else $error("Pause did not demand three-pole trip");
	chk_shot_force:
	assert property (shot != 0 |-> force_three_pole_trip_o)
		else $error("Nonzero shot count without forced trip");
	chk_shot_limit:
	assert property (shot <= max_shot_limit_i)
		else $error("Shot count above limit");
	chk_shot_step:
	assert property ($changed(shot) |-> shot == 0 || shot == $past(shot) + 1 || shot + 1 == $past(shot))
		else $error("Shot count jumped");
	chk_reset_zero:
	assert property ($rose(reset_state_o) |-> ##[0:1] shot == 0)
		else $error("Reset state with nonzero shot count");
	chk_sync_reset:
	assert property (sync_reset_i [*6] |-> reset_state_o && !lockout_o && shot == 0)
		else $error("Synchronous reset ignored");
endmodule
bind lars_sequencer lars_sequencer_sva #(.SW(SW)) u_chk (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .sync_reset_i(sync_reset_i),
	.cycle_pause_input_i(cycle_pause_input_i), .breaker_order_select_i(breaker_order_select_i),
	.max_shot_limit_i(max_shot_limit_i), .reclose_in_progress_flag_o(reclose_in_progress_flag_o),
	.close_cmd_breaker_one_o(close_cmd_breaker_one_o),
	.close_cmd_breaker_two_o(close_cmd_breaker_two_o),
	.force_three_pole_trip_o(force_three_pole_trip_o), .shot_counter_o(shot_counter_o),
	.lockout_o(lockout_o), .reset_state_o(reset_state_o));

// >>> test/tb.sv
// Self-checking bench for the autoreclose sequencer.
// Assumes shortened tick and force counts; breakers are models.
`timescale 1ns/100ps
module tb;
	reg mclk_i, resetn_i, srst, multi, pause, rel, man, trip, oos2, pol, p3;
	reg [2:0] ini, max_shots;
	reg [1:0] stuck, mode, order;
	reg [15:0] tm [0:8];
	wire rip, cl1, cl2, frc, lock, rst_st, b1c, b2c, b1o;
	wire [2:0] shots;
	integer mismatches, n_compared;
	lars_sequencer #(.TICK_CYC(10), .FORCE_CYC(5)) u_lars_sequencer (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .sync_reset_i(srst), .sp_initiate_i(ini[0]),
		.tp_initiate_i(ini[1]), .delayed_three_pole_initiate_i(ini[2]),
		.multi_phase_fault_i(multi), .cycle_pause_input_i(pause), .lockout_release_i(rel),
		.manual_close_i(man), .bkr1_closed_i(b1c), .bkr2_closed_i(b2c),
		.bkr1_three_pole_open_i(b1o & p3), .bkr1_oos_i(1'b0), .bkr2_oos_i(oos2),
		.reclose_program_select_i(mode), .breaker_order_select_i(order),
		.max_shot_limit_i(max_shots), .close_failure_policy_i(pol), .sp_dead_time_i(tm[0]),
		.tp_dead_time1_i(tm[1]), .tp_dead_time2_i(tm[2]), .tp_dead_time3_i(tm[3]),
		.tp_dead_time4_i(tm[4]), .reset_time_i(tm[5]), .incomplete_time_i(tm[6]),
		.transfer_time_i(tm[7]), .close_fail_time_i(tm[8]), .reclose_in_progress_flag_o(rip),
		.close_cmd_breaker_one_o(cl1), .close_cmd_breaker_two_o(cl2),
		.force_three_pole_trip_o(frc), .shot_counter_o(shots), .lockout_o(lock),
		.reset_state_o(rst_st));
	// Slow second breaker so both delays are seen
	lars_breaker_model #(.DELAY(2)) u_bkr1 (.mclk_i(mclk_i), .close_i(cl1 | man),
		.trip_i(trip), .stuck_i(stuck[0]), .closed_o(b1c), .open_o(b1o));
	lars_breaker_model #(.DELAY(12)) u_bkr2 (.mclk_i(mclk_i), .close_i(cl2 | man),
		.trip_i(trip), .stuck_i(stuck[1]), .closed_o(b2c), .open_o());
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// ----------
	// Helpers
	// ----------
	task chk(input [31:0] got, input [31:0] exp);
	begin
		n_compared = n_compared + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task cyc(input integer c);
		repeat (c) @(negedge mclk_i);
	endtask
	function sel(input integer k);
	begin
		case (k)
		0: sel = cl1;
		1: sel = cl2;
		2: sel = lock;
		default: sel = rst_st;
		endcase
	end
	endfunction
	task waitfor(input integer k, input integer lim, output integer n);
	begin
		n = 0;
		while (sel(k) !== 1'b1 && n < lim)
		begin
			cyc(1);
			n = n + 1;
		end
		chk(n < lim, 1);
	end
	endtask
	// First edge enters the cycle and starts the dead time, second edge restarts it
	task fire(input integer k, input p);
	begin
		cyc(1);
		trip = 1'b1;
		ini[k] = 1'b1;
		cyc(8);
		trip = 1'b0;
		ini[k] = 1'b0;
		pause = p;
		cyc(8);
		ini[k] = 1'b1;
		cyc(8);
		ini[k] = 1'b0;
	end
	endtask
	task recover;
		integer n;
	begin
		cyc(1);
		ini = 3'h0;
		multi = 1'b0;
		stuck = 2'h0;
		man = 1'b1;
		rel = 1'b1;
		cyc(20);
		man = 1'b0;
		rel = 1'b0;
		waitfor(3, 400, n);
	end
	endtask
	// ----------
	// Scenarios
	// ----------
	task shot(input integer k, input m, input integer dt, input integer sh, input w);
		integer n;
	begin
		multi = m;
		fire(k, 1'b0);
		if (dt == 0)
		begin
			waitfor(2, 60, n);
			chk({lock, cl1}, 2'h2);
			recover;
		end
		else
		begin
			waitfor(0, 300, n);
			chk(n >= dt * 10 - 10 && n <= dt * 10 + 5, 1);
			cyc(8);
			chk(shots, sh);
			ini = 3'h0;
			multi = 1'b0;
			if (w)
			begin
				waitfor(3, 600, n);
				chk({rst_st, shots}, 4'h8);
			end
		end
	end
	endtask
	task t_reset;
	begin
		chk({rip, cl1, cl2, lock, rst_st, shots}, 8'h08);
		fire(0, 1'b0);
		cyc(8);
		chk(rip, 1);
		srst = 1'b1;
		ini = 3'h0;
		cyc(8);
		srst = 1'b0;
		chk({rip, rst_st, shots}, 5'h08);
	end
	endtask
	task t_force;
		integer n;
	begin
		mode = 2'h0;
		cyc(1);
		ini[0] = 1'b1;
		cyc(6);
		chk(frc, 1'b0);
		ini = 3'h0;
		cyc(14);
		chk(frc, 1'b1);
		waitfor(3, 600, n);
		chk(frc, 1'b0);
	end
	endtask
	task t_pause;
		integer n;
	begin
		fire(0, 1'b1);
		cyc(100);
		chk({cl1, frc}, 2'h1);
		pause = 1'b0;
		waitfor(0, 300, n);
		chk(n >= 88 && n <= 115, 1);
		ini = 3'h0;
		waitfor(3, 600, n);
	end
	endtask
	task t_seq;
		integer n;
	begin
		order = 2'h2;
		oos2 = 1'b0;
		fire(0, 1'b0);
		waitfor(0, 300, n);
		ini = 3'h0;
		waitfor(1, 200, n);
		chk(n >= 42 && n <= 55, 1);
		waitfor(3, 600, n);
		chk({b1c, b2c, shots}, 5'h18);
	end
	endtask
	task t_fail;
		integer n;
	begin
		pol = 1'b0;
		stuck = 2'h1;
		fire(0, 1'b0);
		waitfor(2, 600, n);
		chk({lock, cl2}, 2'h2);
		recover;
		pol = 1'b1;
		stuck = 2'h1;
		fire(0, 1'b0);
		waitfor(1, 600, n);
		chk(lock, 0);
		ini = 3'h0;
		waitfor(2, 800, n);
		chk(lock, 1);
		recover;
	end
	endtask
	initial
	begin
		mismatches = 0;
		n_compared = 0;
		{resetn_i, srst, multi, pause, rel, man, trip, pol} = 8'h00;
		{ini, stuck, mode, order} = 9'h000;
		oos2 = 1'b1;
		p3 = 1'b1;
		max_shots = 3'h1;
		tm[0] = 16'h0003;
		tm[1] = 16'h0006;
		tm[2] = 16'h0009;
		tm[3] = 16'h000c;
		tm[4] = 16'h000f;
		tm[5] = 16'h001e;
		tm[6] = 16'h0028;
		tm[7] = 16'h0005;
		tm[8] = 16'h0014;
		cyc(2);
		resetn_i = 1'b1;
		cyc(6);
		t_reset;
		shot(0, 1'b0, 3, 1, 1'b1);
		shot(1, 1'b1, 6, 1, 1'b1);
		shot(2, 1'b1, 9, 1, 1'b1);
		mode = 2'h1;
		// Single-pole trip leaves the three-pole-open status low
		p3 = 1'b0;
		shot(0, 1'b0, 3, 1, 1'b1);
		p3 = 1'b1;
		shot(0, 1'b0, 0, 0, 1'b0);
		shot(1, 1'b1, 0, 0, 1'b0);
		mode = 2'h2;
		shot(0, 1'b0, 6, 1, 1'b1);
		shot(0, 1'b1, 0, 0, 1'b0);
		mode = 2'h3;
		shot(1, 1'b1, 6, 1, 1'b1);
		shot(2, 1'b1, 9, 1, 1'b1);
		t_force;
		max_shots = 3'h4;
		shot(0, 1'b0, 3, 1, 1'b0);
		shot(1, 1'b1, 9, 2, 1'b0);
		shot(1, 1'b1, 12, 3, 1'b0);
		shot(1, 1'b1, 15, 4, 1'b0);
		shot(1, 1'b1, 0, 0, 1'b0);
		max_shots = 3'h1;
		t_pause;
		t_seq;
		t_fail;
		end_of_test;
	end
	// Whole run is near 5500 cycles; this bound leaves ample room
	initial
	begin
		#400000;
		mismatches = mismatches + 1;
		end_of_test;
	end
endmodule
